// ===== hdl/tmr_out_pkg.sv
// Shared constants for the timer output and interrupt unit.
package tmr_out_pkg;
    localparam int NUM_BLOCKS = 7;
    localparam int CNT_W = 16;
    localparam int VEC_W = 4;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] OFF_COUNT = 8'h00;
    localparam logic [7:0] OFF_PERIOD = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_ENABLES = 8'h10;
    localparam logic [7:0] OFF_VECTOR = 8'h14;
    localparam logic [7:0] OFF_OUTS = 8'h18;
    localparam logic [7:0] OFF_MODE = 8'h1C;
    localparam logic [7:0] OFF_CMP_BASE = 8'h20;
    // Control register fields, and the overflow bits of the enables and flags registers.
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_UPDOWN_BIT = 1;
    localparam int CTRL_FLOAT_SEL_BIT = 2;
    localparam int CTRL_GIE_BIT = 3;
    localparam int CTRL_CAPMODE_LSB = 8;
    localparam int ENA_OVF_BIT = 7;
    localparam int FLAG_OVF_BIT = 7;
    // Period value after reset, and the output mode codes.
    localparam logic [CNT_W-1:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [2:0] MODE_OUTPUT = 3'h0;
    localparam logic [2:0] MODE_SET = 3'h1;
    localparam logic [2:0] MODE_TOG_RST = 3'h2;
    localparam logic [2:0] MODE_SET_RST = 3'h3;
    localparam logic [2:0] MODE_TOGGLE = 3'h4;
    localparam logic [2:0] MODE_RESET = 3'h5;
    localparam logic [2:0] MODE_TOG_SET = 3'h6;
    localparam logic [2:0] MODE_RST_SET = 3'h7;
    // Vector codes.
    localparam logic [VEC_W-1:0] VEC_NONE = 4'h0;
    localparam logic [VEC_W-1:0] VEC_OVERFLOW = 4'hE;
endpackage

// ===== hdl/tmr_out_unit.sv
// Timer output modes, event flags and prioritised interrupt vector with APB registers.
// Contract
// [R01] Mode 000: output follows software bit immediately, combinationally.
// [R02] Mode 001: output set at compare match, held.
// [R03] Modes 010/110: toggle at compare; low/high at period match.
// [R04] Mode 011 set/reset, mode 111 reset/set on compare/period.
// [R05] Mode 100: toggle on every compare match.
// [R06] Mode 101: output cleared at compare match, held.
// [R07] Up mode: period action at rollover from period to zero.
// [R08] Up/down: compare fires on equality either direction; period on equality.
// [R09] Software keeps a mode bit set while changing modes.
// [R10] Software passes through mode 7 when changing modes.
// [R11] Two interrupt lines: block zero alone, and all others shared.
// [R12] Capture sets the block event flag.
// [R13] Compare match sets the block event flag.
// [R14] Software may set or clear any block event flag.
// [R15] Flag requests interrupt only with block and global enables set.
// [R16] Block zero flag highest, own line, cleared on acknowledge.
// [R17] Overflow and blocks one up merge into one shared request.
// [R18] Vector shows highest enabled pending source only.
// [R19] Vector read or write clears highest pending flag.
// [R20] Code 0 none, 2 block one, 4 block two; one wins.
// [R21] Codes 6..12 blocks three to six; 14 overflow, lowest.
// [R22] Non-zero modes change output only on clock edge.
// [R23] Per-block equal pulse; block zero pulse marks period match. The code takes period match from period_latch, not from block zero's compare.
// [R24] Float pin high with function selected tristates all outputs.
// [R25] Overflow flag set on wrap to zero; cleared by software or vector.
// [R26] Shared request high while any enabled shared source is pending.
`timescale 1ns/1ps
`default_nettype none
module tmr_out_unit (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [6:0] capture_in,
    input wire logic output_float_pin,
    input wire logic block_zero_irq_ack,
    output logic block_zero_irq,
    output logic shared_irq,
    output logic [6:0] unit_output,
    output logic [6:0] unit_output_oe
);
    localparam int N = tmr_out_pkg::NUM_BLOCKS;

    typedef struct packed {
        logic [15:0] count;
        logic dir_down;
        logic [15:0] period_latch;
        logic [31:0] ctrl;
        logic [N-1:0] block_event_flag;
        logic overflow_flag;
        logic [N-1:0] block_event_enable;
        logic overflow_enable;
        logic [N-1:0] out_bit;
        logic [N-1:0] out_state;
        logic [N*3-1:0] output_mode_field;
        logic [N*16-1:0] compare_latch;
        logic [N*16-1:0] block_register;
        logic [N-1:0] cap_s1;
        logic [N-1:0] cap_s2;
        logic [N-1:0] cap_s3;
        logic flt_s1;
        logic flt_s2;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq0;
        logic irqs;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [N-1:0] cmp_eq;
    logic period_eq;
    logic wrap;
    logic [3:0] vec;
    logic vec_hit;
    logic [2:0] vec_idx;
    logic acc;
    logic acc_wr;
    logic [N-1:0] shared_pend;

    // Compare equality and period event decode.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            cmp_eq[i] = s_q.ctrl[tmr_out_pkg::CTRL_RUN_BIT] && !s_q.ctrl[tmr_out_pkg::CTRL_CAPMODE_LSB + i]
                && (s_q.count == s_q.compare_latch[i*16 +: 16]); // [R08] [R23]
        end
        wrap = s_q.ctrl[tmr_out_pkg::CTRL_RUN_BIT] && !s_q.ctrl[tmr_out_pkg::CTRL_UPDOWN_BIT]
            && (s_q.count == s_q.period_latch); // [R07]
        // In up/down the period action fires on equality; in up mode on the rollover.
        period_eq = s_q.ctrl[tmr_out_pkg::CTRL_RUN_BIT] && (s_q.count == s_q.period_latch); // [R08] [R23]
    end

    // Priority encoder over shared sources; block one wins, overflow last.
    always_comb begin
        vec = tmr_out_pkg::VEC_NONE;
        vec_hit = 1'b0;
        vec_idx = 3'h0;
        shared_pend = s_q.block_event_flag & s_q.block_event_enable; // [R18]
        shared_pend[0] = 1'b0;
        if (s_q.overflow_flag && s_q.overflow_enable) begin
            vec = tmr_out_pkg::VEC_OVERFLOW; // [R21]
            vec_hit = 1'b1;
            vec_idx = 3'h7;
        end
        for (int i = N - 1; i >= 1; i--) begin
            if (shared_pend[i]) begin
                vec = 4'(2 * i); // [R20] [R21]
                vec_hit = 1'b1;
                vec_idx = 3'(i);
            end
        end
    end

    assign acc = psel && penable && !s_q.ready;
    assign acc_wr = acc && pwrite;

    always_comb begin
        logic [2:0] m;
        logic o;
        logic per;
        m = 3'h0;
        o = 1'b0;
        per = 1'b0;
        s_d = s_q;
        s_d.ready = 1'b0;
        s_d.slverr = 1'b0;
        s_d.cap_s1 = capture_in;
        s_d.cap_s2 = s_q.cap_s1;
        s_d.cap_s3 = s_q.cap_s2;
        s_d.flt_s1 = output_float_pin;
        s_d.flt_s2 = s_q.flt_s1;

        // Counter: up mode wraps at the period, up/down turns at period and zero.
        if (s_q.ctrl[tmr_out_pkg::CTRL_RUN_BIT]) begin
            if (!s_q.ctrl[tmr_out_pkg::CTRL_UPDOWN_BIT]) begin
                s_d.count = wrap ? 16'h0000 : s_q.count + 16'h0001;
                s_d.dir_down = 1'b0;
            end else if (s_q.dir_down) begin
                s_d.count = s_q.count - 16'h0001;
                if (s_q.count == 16'h0001) begin
                    s_d.dir_down = 1'b0;
                end
            end else begin
                s_d.count = s_q.count + 16'h0001;
                if (s_d.count >= s_q.period_latch) begin
                    s_d.dir_down = 1'b1;
                end
            end
        end

        // Output unit per block; all non-zero modes update only here at the clock.
        for (int i = 0; i < N; i++) begin
            m = s_q.output_mode_field[i*3 +: 3];
            o = s_q.out_state[i];
            per = s_q.ctrl[tmr_out_pkg::CTRL_UPDOWN_BIT] ? period_eq : wrap;
            case (m) // [R22]
                tmr_out_pkg::MODE_OUTPUT: o = s_q.out_bit[i];
                tmr_out_pkg::MODE_SET: if (cmp_eq[i]) o = 1'b1; // [R02]
                tmr_out_pkg::MODE_TOG_RST: begin
                    if (cmp_eq[i]) o = ~o; // [R03]
                    if (per) o = 1'b0; // [R03]
                end
                tmr_out_pkg::MODE_SET_RST: begin
                    if (cmp_eq[i]) o = 1'b1; // [R04]
                    if (per) o = 1'b0; // [R04]
                end
                tmr_out_pkg::MODE_TOGGLE: if (cmp_eq[i]) o = ~o; // [R05]
                tmr_out_pkg::MODE_RESET: if (cmp_eq[i]) o = 1'b0; // [R06]
                tmr_out_pkg::MODE_TOG_SET: begin
                    if (cmp_eq[i]) o = ~o; // [R03]
                    if (per) o = 1'b1; // [R03]
                end
                tmr_out_pkg::MODE_RST_SET: begin
                    if (cmp_eq[i]) o = 1'b0; // [R04]
                    if (per) o = 1'b1; // [R04]
                end
                default: o = s_q.out_state[i];
            endcase
            s_d.out_state[i] = o;
        end

        // Software writes; hardware sets below override clears made here.
        if (acc_wr) begin
            case (paddr)
                tmr_out_pkg::OFF_COUNT: s_d.count = pwdata[15:0];
                tmr_out_pkg::OFF_PERIOD: s_d.period_latch = pwdata[15:0];
                tmr_out_pkg::OFF_CTRL: s_d.ctrl = pwdata;
                tmr_out_pkg::OFF_FLAGS: begin
                    s_d.block_event_flag = pwdata[N-1:0]; // [R14]
                    s_d.overflow_flag = pwdata[tmr_out_pkg::FLAG_OVF_BIT]; // [R25]
                end
                tmr_out_pkg::OFF_ENABLES: begin
                    s_d.block_event_enable = pwdata[N-1:0];
                    s_d.overflow_enable = pwdata[tmr_out_pkg::ENA_OVF_BIT];
                end
                tmr_out_pkg::OFF_OUTS: s_d.out_bit = pwdata[N-1:0];
                tmr_out_pkg::OFF_MODE: s_d.output_mode_field = pwdata[N*3-1:0];
                default: begin
                    for (int i = 0; i < N; i++) begin
                        if (paddr == tmr_out_pkg::OFF_CMP_BASE + 8'(4 * i)) begin
                            s_d.block_register[i*16 +: 16] = pwdata[15:0];
                            s_d.compare_latch[i*16 +: 16] = pwdata[15:0];
                        end
                    end
                end
            endcase
        end

        // Vector access clears the highest pending shared source.
        if (acc && paddr == tmr_out_pkg::OFF_VECTOR && vec_hit) begin
            if (vec_idx == 3'h7) begin
                s_d.overflow_flag = 1'b0; // [R19] [R25]
            end else begin
                s_d.block_event_flag[vec_idx] = 1'b0; // [R19]
            end
        end
        if (block_zero_irq_ack) begin
            s_d.block_event_flag[0] = 1'b0; // [R16]
        end

        // Hardware events; set wins over any clear this cycle.
        for (int i = 0; i < N; i++) begin
            if (s_q.ctrl[tmr_out_pkg::CTRL_CAPMODE_LSB + i] && (s_q.cap_s2[i] != s_q.cap_s3[i])) begin
                s_d.block_register[i*16 +: 16] = s_q.count;
                s_d.block_event_flag[i] = 1'b1; // [R12]
            end
            if (cmp_eq[i]) begin
                s_d.block_event_flag[i] = 1'b1; // [R13]
            end
        end
        if (s_q.ctrl[tmr_out_pkg::CTRL_RUN_BIT] && s_d.count == 16'h0000 && s_q.count != 16'h0000) begin
            s_d.overflow_flag = 1'b1; // [R25]
        end

        s_d.irq0 = s_d.block_event_flag[0] && s_d.block_event_enable[0]
            && s_d.ctrl[tmr_out_pkg::CTRL_GIE_BIT]; // [R11] [R15] [R16]
        s_d.irqs = s_d.ctrl[tmr_out_pkg::CTRL_GIE_BIT]
            && (|(s_d.block_event_flag[N-1:1] & s_d.block_event_enable[N-1:1])
            || (s_d.overflow_flag && s_d.overflow_enable)); // [R15] [R17] [R26]

        // APB answer one cycle after the access phase starts.
        if (acc) begin
            s_d.ready = 1'b1;
            s_d.rdata = 32'h0000_0000;
            case (paddr)
                tmr_out_pkg::OFF_COUNT: s_d.rdata = {16'h0000, s_q.count};
                tmr_out_pkg::OFF_PERIOD: s_d.rdata = {16'h0000, s_q.period_latch};
                tmr_out_pkg::OFF_CTRL: s_d.rdata = s_q.ctrl;
                tmr_out_pkg::OFF_FLAGS: s_d.rdata = {24'h000000, s_q.overflow_flag, s_q.block_event_flag};
                tmr_out_pkg::OFF_ENABLES: s_d.rdata = {24'h000000, s_q.overflow_enable, s_q.block_event_enable};
                tmr_out_pkg::OFF_VECTOR: s_d.rdata = {28'h0000000, vec}; // [R18]
                tmr_out_pkg::OFF_OUTS: s_d.rdata = {25'h0000000, s_q.out_state};
                tmr_out_pkg::OFF_MODE: s_d.rdata = {11'h000, s_q.output_mode_field};
                default: begin
                    s_d.slverr = 1'b1;
                    for (int i = 0; i < N; i++) begin
                        if (paddr == tmr_out_pkg::OFF_CMP_BASE + 8'(4 * i)) begin
                            s_d.slverr = 1'b0;
                            s_d.rdata = {16'h0000, s_q.block_register[i*16 +: 16]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.period_latch <= tmr_out_pkg::PERIOD_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.slverr;
    assign block_zero_irq = s_q.irq0;
    assign shared_irq = s_q.irqs;

    // Mode zero passes the stored bit straight through so a write shows at the edge that stores it, not one edge later.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            unit_output[i] = (s_q.output_mode_field[i*3 +: 3] == tmr_out_pkg::MODE_OUTPUT)
                ? s_q.out_bit[i] : s_q.out_state[i]; // [R01]
            unit_output_oe[i] = !(s_q.ctrl[tmr_out_pkg::CTRL_FLOAT_SEL_BIT] && s_q.flt_s2); // [R24]
        end
    end
endmodule // tmr_out_unit
`default_nettype wire

// ===== testbench/pin_load_model.sv
// Load on the timer output pins, with a pull-down on each pin.
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
    input wire logic [6:0] unit_output,
    input wire logic [6:0] unit_output_oe,
    output logic [6:0] pin_level
);
    // A released pin falls to the pull-down instead of keeping its last value.
    assign pin_level = unit_output & unit_output_oe;
endmodule // pin_load_model
`default_nettype wire

// ===== testbench/tmr_out_unit_properties.sv
// Port-level properties of the timer output and interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module tmr_out_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic output_float_pin,
    input wire logic block_zero_irq,
    input wire logic shared_irq,
    input wire logic [6:0] unit_output,
    input wire logic [6:0] unit_output_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic vec_rd;
    assign vec_rd = pready && !pslverr && !pwrite && paddr == tmr_out_pkg::OFF_VECTOR;
    answer_next_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad data");
    vector_code_a: assert property (vec_rd |-> prdata[31:4] == 28'h0 && !prdata[0]) else $error("bad code");
    pending_code_a: assert property (vec_rd && $past(shared_irq) |-> prdata[3:0] != 4'h0) else $error("code 0");
    float_all_a: assert property (unit_output_oe == 7'h00 || unit_output_oe == 7'h7F) else $error("split float");
    float_cause_a: assert property (unit_output_oe == 7'h00 |-> $past(output_float_pin, 2)
        || $past(output_float_pin, 3)) else $error("float without pin");
    reset_quiet_a: assert property ($past(reset) |-> unit_output == 7'h00 && !block_zero_irq
        && !shared_irq) else $error("not quiet after reset");
    cover property (unit_output_oe == 7'h00);
    cover property (vec_rd && prdata[3:0] != 4'h0);
    cover property (block_zero_irq);
    cover property (pslverr);
endmodule // tmr_out_checker
bind tmr_out_unit tmr_out_checker chk_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_float_pin(output_float_pin), .block_zero_irq(block_zero_irq), .shared_irq(shared_irq),
    .unit_output(unit_output), .unit_output_oe(unit_output_oe));
`default_nettype wire

// ===== testbench/timer_output_and_irq_unit_bench.sv
// Self-checking bench for the timer output and interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module timer_output_and_irq_unit_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic float_in = 1'b0;
    logic ack = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [6:0] cap = 7'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, bz_irq, sh_irq;
    logic [6:0] uo, uo_oe, pins;
    int n_mismatch = 0;
    int cmp_count = 0;
    tmr_out_unit dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_in(cap), .output_float_pin(float_in), .block_zero_irq_ack(ack),
        .block_zero_irq(bz_irq), .shared_irq(sh_irq), .unit_output(uo), .unit_output_oe(uo_oe));
    pin_load_model load (.unit_output(uo), .unit_output_oe(uo_oe), .pin_level(pins));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 32'h1, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    // Passing through mode 7 keeps one mode bit set, so the mode-zero decode never glitches.
    task automatic mode(input logic [2:0] m);
        wr(tmr_out_pkg::OFF_MODE, 32'h38);
        wr(tmr_out_pkg::OFF_MODE, {26'h0, m, 3'h0});
    endtask
    task automatic step(input logic [2:0] m, input logic per, input logic e);
        mode(m);
        wr(tmr_out_pkg::OFF_COUNT, per ? 32'h26 : 32'h08);
        wr(tmr_out_pkg::OFF_CTRL, 32'h1);
        wr(tmr_out_pkg::OFF_CTRL, 32'h0);
        chk("unit_output", {31'h0, e}, {31'h0, uo[1]});
    endtask
    task automatic gap(output int g);
        logic v;
        v = uo[1];
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (uo[1] === v && g < 200);
    endtask
    task automatic t_mode0;
        wr(tmr_out_pkg::OFF_MODE, 32'h0);
        wr(tmr_out_pkg::OFF_OUTS, 32'h55);
        chk("unit_output", 32'h55, {25'h0, uo});
        rdc("unmapped", 8'hFC, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        $display("mode zero done");
    endtask
    task automatic t_modes;
        wr(tmr_out_pkg::OFF_PERIOD, 32'h28);
        wr(tmr_out_pkg::OFF_CMP_BASE, 32'h28);
        wr(tmr_out_pkg::OFF_CMP_BASE + 8'h04, 32'h0A);
        step(3'h5, 1'b0, 1'b0);
        step(3'h5, 1'b1, 1'b0);
        step(3'h1, 1'b0, 1'b1);
        step(3'h1, 1'b1, 1'b1);
        step(3'h2, 1'b0, 1'b0);
        step(3'h2, 1'b0, 1'b1);
        step(3'h2, 1'b1, 1'b0);
        step(3'h6, 1'b1, 1'b1);
        step(3'h6, 1'b0, 1'b0);
        step(3'h3, 1'b0, 1'b1);
        step(3'h3, 1'b1, 1'b0);
        step(3'h7, 1'b1, 1'b1);
        step(3'h7, 1'b0, 1'b0);
        step(3'h4, 1'b0, 1'b1);
        step(3'h4, 1'b0, 1'b0);
        // Up/down run from 38 meets the period latch at 40 on the way up, so mode 3 must reset.
        step(3'h3, 1'b0, 1'b1);
        wr(tmr_out_pkg::OFF_COUNT, 32'h26);
        wr(tmr_out_pkg::OFF_CTRL, 32'h3);
        wr(tmr_out_pkg::OFF_CTRL, 32'h0);
        chk("unit_output", 32'h0, {31'h0, uo[1]});
        $display("output modes done");
    endtask
    task automatic t_toggle(input logic updown);
        int g1, g2;
        mode(3'h4);
        wr(tmr_out_pkg::OFF_COUNT, 32'h0);
        wr(tmr_out_pkg::OFF_CTRL, {30'h0, updown, 1'b1});
        gap(g1);
        gap(g1);
        gap(g2);
        wr(tmr_out_pkg::OFF_CTRL, 32'h0);
        if (updown) begin
            chk("gap sum", 32'h50, 32'(g1 + g2));
            chk("gap", 32'h1, {31'h0, g1 == 20 || g1 == 60});
        end else begin
            chk("gap", 32'h29, 32'(g2));
        end
        $display("toggle timing done");
    endtask
    task automatic t_irq;
        wr(tmr_out_pkg::OFF_FLAGS, 32'h0);
        step(3'h1, 1'b0, 1'b1);
        rdc("flags", tmr_out_pkg::OFF_FLAGS, 32'h02);
        wr(tmr_out_pkg::OFF_FLAGS, 32'h0);
        step(3'h1, 1'b1, 1'b1);
        rdc("flags", tmr_out_pkg::OFF_FLAGS, 32'hFD);
        wr(tmr_out_pkg::OFF_CTRL, 32'h8);
        wr(tmr_out_pkg::OFF_ENABLES, 32'hFF);
        wr(tmr_out_pkg::OFF_FLAGS, 32'hFE);
        chk("shared_irq", 32'h1, {31'h0, sh_irq});
        for (int i = 1; i <= 8; i++) rdc("vector", tmr_out_pkg::OFF_VECTOR, i == 8 ? 32'h0 : 32'(2 * i));
        chk("shared_irq", 32'h0, {31'h0, sh_irq});
        wr(tmr_out_pkg::OFF_ENABLES, 32'hFD);
        wr(tmr_out_pkg::OFF_FLAGS, 32'h0A);
        rdc("vector", tmr_out_pkg::OFF_VECTOR, 32'h6);
        rdc("flags", tmr_out_pkg::OFF_FLAGS, 32'h02);
        wr(tmr_out_pkg::OFF_FLAGS, 32'h04);
        wr(tmr_out_pkg::OFF_ENABLES, 32'hFF);
        wr(tmr_out_pkg::OFF_VECTOR, 32'h0);
        rdc("flags", tmr_out_pkg::OFF_FLAGS, 32'h0);
        wr(tmr_out_pkg::OFF_FLAGS, 32'h01);
        chk("irq lines", 32'h2, {30'h0, bz_irq, sh_irq});
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk("block_zero_irq", 32'h0, {31'h0, bz_irq});
        wr(tmr_out_pkg::OFF_ENABLES, 32'hFE);
        wr(tmr_out_pkg::OFF_FLAGS, 32'h03);
        wr(tmr_out_pkg::OFF_CTRL, 32'h0);
        chk("irq lines", 32'h0, {30'h0, bz_irq, sh_irq});
        wr(tmr_out_pkg::OFF_FLAGS, 32'h0);
        wr(tmr_out_pkg::OFF_CTRL, 32'h200);
        @(posedge clk);
        cap <= 7'h02;
        repeat (5) @(posedge clk);
        rdc("flags", tmr_out_pkg::OFF_FLAGS, 32'h02);
        // The counter was left at 1 by the last rollover run and has not run since.
        rdc("captured count", tmr_out_pkg::OFF_CMP_BASE + 8'h04, 32'h1);
        $display("interrupts done");
    endtask
    task automatic t_float;
        wr(tmr_out_pkg::OFF_MODE, 32'h0);
        wr(tmr_out_pkg::OFF_OUTS, 32'h7F);
        wr(tmr_out_pkg::OFF_CTRL, 32'h4);
        float_in <= 1'b1;
        repeat (5) @(posedge clk);
        chk("oe pins", 32'h0, {18'h0, uo_oe, pins});
        float_in <= 1'b0;
        repeat (5) @(posedge clk);
        chk("oe pins", 32'h3FFF, {18'h0, uo_oe, pins});
        $display("float done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_mode0;
        t_modes;
        t_toggle(1'b0);
        t_toggle(1'b1);
        t_irq;
        t_float;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
endmodule // timer_output_and_irq_unit_bench
`default_nettype wire
